/* File: src/audio_dac_port.sv */
`timescale 1ns/1ps
// Purpose: Device end: serial audio receiver, clock master and filter coefficients.
// Assumes: Control port writes come on clk; link pins are asynchronous.
// Notes: Samples are left aligned in 32 bits.
module audio_dac_port (
  input wire logic clk,
  input wire logic srst,
  audio_link_if.device_end link,
  output logic [31:0] leftSample,
  output logic [31:0] rightSample,
  output logic sampleValid,
  output logic [15:0] tapZeroCoef,
  output logic [15:0] tapOneCoef,
  output logic [15:0] tapCentreCoef,
  output logic [15:0] tapThreeCoef,
  output logic [15:0] tapFourCoef,
  output logic fastControlMode
);
  typedef struct packed {
    logic [7:0] dacSetup;
    logic [7:0] ifCtrl;
    logic [15:0] coefOuter;
    logic [15:0] coefInner;
    logic [15:0] coefCentre;
    logic [7:0] rdData;
    logic [1:0] clkSync;
    logic [1:0] wsSync;
    logic [1:0] datSync;
    logic bclkPrev;
    logic wsPrev;
    logic [7:0] phaseCnt;
    logic bclkOut;
    logic wsOut;
    logic [5:0] bitIdx;
    logic [31:0] shiftWord;
    logic [5:0] bitCnt;
    logic [31:0] leftHold;
    logic [31:0] leftOut;
    logic [31:0] rightOut;
    logic valid;
    logic [15:0] tap0;
    logic [15:0] tap1;
    logic [15:0] tap2;
  } dev_state_t;

  dev_state_t s_reg, s_next;

  function automatic logic [31:0] alignWord(input logic [31:0] w, input logic [5:0] n);
    alignWord = (n == 6'h0) ? 32'h0 : w << (6'h20 - n);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic master, usbMode, bclkNow, wsNow, rise, lastPhase;
  logic [7:0] phaseLimit;
  logic [5:0] wordBits;
  logic [31:0] doneWord;
  logic [5:0] doneCnt;

  always_comb
  begin
    s_next = s_reg;
    master = s_reg.ifCtrl[audio_port_pkg::MASTER_BIT];
    usbMode = s_reg.dacSetup[1:0] == audio_port_pkg::OSR_USB_CODE;
    doneWord = s_reg.shiftWord;
    doneCnt = s_reg.bitCnt;
    // Control port writes and registered read back.
    if (link.regWrite)
    begin
      case (link.regAddr)
        audio_port_pkg::DAC_SETUP_ADDR: s_next.dacSetup = link.regWrData;
        audio_port_pkg::SERIAL_IF_ADDR: s_next.ifCtrl = link.regWrData;
        audio_port_pkg::COEF_OUTER_LO_ADDR: s_next.coefOuter[7:0] = link.regWrData;
        audio_port_pkg::COEF_OUTER_HI_ADDR: s_next.coefOuter[15:8] = link.regWrData;
        audio_port_pkg::COEF_INNER_LO_ADDR: s_next.coefInner[7:0] = link.regWrData;
        audio_port_pkg::COEF_INNER_HI_ADDR: s_next.coefInner[15:8] = link.regWrData;
        audio_port_pkg::COEF_CENTRE_LO_ADDR: s_next.coefCentre[7:0] = link.regWrData;
        audio_port_pkg::COEF_CENTRE_HI_ADDR: s_next.coefCentre[15:8] = link.regWrData;
        default: ;
      endcase
    end
    case (link.regAddr)
      audio_port_pkg::DAC_SETUP_ADDR: s_next.rdData = s_reg.dacSetup;
      audio_port_pkg::SERIAL_IF_ADDR: s_next.rdData = s_reg.ifCtrl;
      audio_port_pkg::COEF_OUTER_LO_ADDR: s_next.rdData = s_reg.coefOuter[7:0];
      audio_port_pkg::COEF_OUTER_HI_ADDR: s_next.rdData = s_reg.coefOuter[15:8];
      audio_port_pkg::COEF_INNER_LO_ADDR: s_next.rdData = s_reg.coefInner[7:0];
      audio_port_pkg::COEF_INNER_HI_ADDR: s_next.rdData = s_reg.coefInner[15:8];
      audio_port_pkg::COEF_CENTRE_LO_ADDR: s_next.rdData = s_reg.coefCentre[7:0];
      audio_port_pkg::COEF_CENTRE_HI_ADDR: s_next.rdData = s_reg.coefCentre[15:8];
      default: s_next.rdData = 8'h0;
    endcase
    // Filter coefficient selection.
    if (s_reg.dacSetup[audio_port_pkg::CUSTOM_FILTER_BIT])
    begin
      s_next.tap0 = s_reg.coefOuter;
      s_next.tap1 = s_reg.coefInner;
      s_next.tap2 = s_reg.coefCentre;
    end
    else if (usbMode)
    begin
      s_next.tap0 = audio_port_pkg::USB_OUTER;
      s_next.tap1 = audio_port_pkg::USB_INNER;
      s_next.tap2 = audio_port_pkg::USB_CENTRE;
    end
    else
    begin
      s_next.tap0 = audio_port_pkg::STD_OUTER;
      s_next.tap1 = audio_port_pkg::STD_INNER;
      s_next.tap2 = audio_port_pkg::STD_CENTRE;
    end
    // Pin synchronisers.
    s_next.clkSync = {s_reg.clkSync[0], link.bitClk};
    s_next.wsSync = {s_reg.wsSync[0], link.audioWordSelectPin};
    s_next.datSync = {s_reg.datSync[0], link.audioSerialDataPin};
    // Bit clock and word select generator.
    if (usbMode)
    begin
      phaseLimit = s_reg.bclkOut ? audio_port_pkg::USB_HIGH_CYCLES
        : audio_port_pkg::USB_LOW_CYCLES;
      wordBits = audio_port_pkg::USB_BITS;
    end
    else
    begin
      phaseLimit = audio_port_pkg::HALF_CYCLES;
      wordBits = s_reg.ifCtrl[audio_port_pkg::WORD32_BIT] ? audio_port_pkg::LONG_BITS
        : audio_port_pkg::SHORT_BITS;
    end
    lastPhase = s_reg.phaseCnt >= phaseLimit - 8'h1;
    if (!master)
    begin
      s_next.phaseCnt = 8'h0;
      s_next.bclkOut = 1'b0;
      s_next.bitIdx = 6'h0;
    end
    else if (lastPhase)
    begin
      s_next.phaseCnt = 8'h0;
      s_next.bclkOut = !s_reg.bclkOut;
      if (s_reg.bclkOut)
      begin
        if (s_reg.bitIdx >= wordBits - 6'h1)
        begin
          s_next.bitIdx = 6'h0;
          s_next.wsOut = !s_reg.wsOut;
        end
        else
          s_next.bitIdx = s_reg.bitIdx + 6'h1;
      end
    end
    else
      s_next.phaseCnt = s_reg.phaseCnt + 8'h1;
    // Receiver: sample on each rising bit clock edge.
    bclkNow = master ? s_reg.bclkOut : s_reg.clkSync[1];
    wsNow = master ? s_reg.wsOut : s_reg.wsSync[1];
    rise = bclkNow && !s_reg.bclkPrev;
    s_next.bclkPrev = bclkNow;
    s_next.valid = 1'b0;
    if (rise)
    begin
      s_next.wsPrev = wsNow;
      if (wsNow != s_reg.wsPrev)
      begin
        if (s_reg.ifCtrl[audio_port_pkg::LEFT_JUST_BIT])
        begin
          s_next.shiftWord = {31'h0, s_reg.datSync[1]};
          s_next.bitCnt = 6'h1;
        end
        else
        begin
          if (s_reg.bitCnt < 6'h20)
          begin
            doneWord = {s_reg.shiftWord[30:0], s_reg.datSync[1]};
            doneCnt = s_reg.bitCnt + 6'h1;
          end
          s_next.shiftWord = 32'h0;
          s_next.bitCnt = 6'h0;
        end
        // Any word length is accepted; bits past 32 are dropped.
        if (!s_reg.wsPrev)
          s_next.leftHold = alignWord(doneWord, doneCnt);
        else
        begin
          s_next.leftOut = s_reg.leftHold;
          s_next.rightOut = alignWord(doneWord, doneCnt);
          s_next.valid = 1'b1;
        end
      end
      else if (s_reg.bitCnt < 6'h20)
      begin
        s_next.shiftWord = {s_reg.shiftWord[30:0], s_reg.datSync[1]};
        s_next.bitCnt = s_reg.bitCnt + 6'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.devBitClk = s_reg.bclkOut;
  assign link.devWordSel = s_reg.wsOut;
  assign link.devBitClkOeN = !s_reg.ifCtrl[audio_port_pkg::MASTER_BIT];
  assign link.devWordSelOeN = !s_reg.ifCtrl[audio_port_pkg::MASTER_BIT];
  assign link.regRdData = s_reg.rdData;
  assign leftSample = s_reg.leftOut;
  assign rightSample = s_reg.rightOut;
  assign sampleValid = s_reg.valid;
  assign tapZeroCoef = s_reg.tap0;
  assign tapOneCoef = s_reg.tap1;
  assign tapCentreCoef = s_reg.tap2;
  assign tapThreeCoef = s_reg.tap1;
  assign tapFourCoef = s_reg.tap0;
  assign fastControlMode = s_reg.ifCtrl[audio_port_pkg::FAST_CTRL_BIT];
endmodule

/* File: src/audio_link_if.sv */
`timescale 1ns/1ps
// Purpose: Serial audio link and control port between source and device.
// Assumes: Two-way pins are resolved here from the output enables.
// Notes: Undriven clock and word select read low.
interface audio_link_if;
  logic devBitClk, devBitClkOeN, hostBitClk, hostBitClkOeN;
  logic devWordSel, devWordSelOeN, hostWordSel, hostWordSelOeN;
  logic bitClk, audioWordSelectPin, audioSerialDataPin;
  logic [7:0] regAddr, regWrData, regRdData;
  logic regWrite;
  assign bitClk = !devBitClkOeN ? devBitClk : (!hostBitClkOeN ? hostBitClk : 1'b0);
  assign audioWordSelectPin = !devWordSelOeN ? devWordSel :
    (!hostWordSelOeN ? hostWordSel : 1'b0);
  modport device_end (
    input bitClk, audioWordSelectPin, audioSerialDataPin, regAddr, regWrData, regWrite,
    output devBitClk, devBitClkOeN, devWordSel, devWordSelOeN, regRdData
  );
  modport host_end (
    input bitClk, audioWordSelectPin, regRdData,
    output hostBitClk, hostBitClkOeN, hostWordSel, hostWordSelOeN, audioSerialDataPin,
    output regAddr, regWrData, regWrite
  );
endinterface

/* File: src/audio_port_pkg.sv */
// Purpose: Shared constants for the serial audio port and its audio source.
// Assumes: Both ends run on clk at 250 MHz.
// Notes: Device register offsets are byte addresses on the device control port; source offsets are AXI4-Lite byte addresses.
// Notes on behaviour
// - Master bit drives bit clock and word select.
// - Master word length bit picks 32 or 16.
// - Slave decodes any word length.
// - Timing bit picks left-justified or normal framing.
// - Fast bit raises control port speed limit.
// - USB mode master: 25 bits, 40/60 duty.
// - Other modes master: 32/16 bits, 50-50 duty.
// - Oversampling code 00 is USB mode.
// - Bit clock up to 3.072 MHz both roles.
// - Three 16-bit coefficients, two byte writes each.
// - Bytes 10h/11h hold outer tap coefficient.
// - Bytes 12h/13h hold inner tap coefficient.
// - Bytes 14h/15h hold centre tap coefficient.
// - Taps mirrored about centre for linear phase.
// - Software writes coefficients as two's complement.
// - Default set 434, -2291, 26984 in mode 00.
// - Default set 61, -371, 25699 otherwise.
// - Software keeps custom set power within defaults.
// - Setup bit 6 selects programmed coefficients.
package audio_port_pkg;
  // ----------------------------------------------------------------
  // Device control port map
  // ----------------------------------------------------------------
  localparam logic [7:0] DAC_SETUP_ADDR = 8'h0e;
  localparam logic [7:0] SERIAL_IF_ADDR = 8'h0f;
  localparam logic [7:0] COEF_OUTER_LO_ADDR = 8'h10;
  localparam logic [7:0] COEF_OUTER_HI_ADDR = 8'h11;
  localparam logic [7:0] COEF_INNER_LO_ADDR = 8'h12;
  localparam logic [7:0] COEF_INNER_HI_ADDR = 8'h13;
  localparam logic [7:0] COEF_CENTRE_LO_ADDR = 8'h14;
  localparam logic [7:0] COEF_CENTRE_HI_ADDR = 8'h15;
  localparam int MASTER_BIT = 0;
  localparam int WORD32_BIT = 1;
  localparam int LEFT_JUST_BIT = 2;
  localparam int FAST_CTRL_BIT = 3;
  localparam int CUSTOM_FILTER_BIT = 6;
  localparam logic [1:0] OSR_USB_CODE = 2'h0;
  localparam logic [15:0] USB_OUTER = 16'h01b2;
  localparam logic [15:0] USB_INNER = 16'hf70d;
  localparam logic [15:0] USB_CENTRE = 16'h6968;
  localparam logic [15:0] STD_OUTER = 16'h003d;
  localparam logic [15:0] STD_INNER = 16'hfe8d;
  localparam logic [15:0] STD_CENTRE = 16'h6463;
  // ----------------------------------------------------------------
  // Bit clock timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 250000;
  localparam int BCLK_MAX_KHZ = 3072;
  localparam int BCLK_MIN_CYCLES = (CLK_KHZ + BCLK_MAX_KHZ - 1) / BCLK_MAX_KHZ;
  localparam int BCLK_UNIT = (BCLK_MIN_CYCLES + 9) / 10;
  localparam logic [7:0] HALF_CYCLES = 8'(5 * BCLK_UNIT);
  localparam logic [7:0] USB_HIGH_CYCLES = 8'(4 * BCLK_UNIT);
  localparam logic [7:0] USB_LOW_CYCLES = 8'(6 * BCLK_UNIT);
  localparam logic [5:0] USB_BITS = 6'h19;
  localparam logic [5:0] LONG_BITS = 6'h20;
  localparam logic [5:0] SHORT_BITS = 6'h10;
  // ----------------------------------------------------------------
  // Audio source register map (AXI4-Lite)
  // ----------------------------------------------------------------
  localparam logic [7:0] SRC_CTRL_ADDR = 8'h00;
  localparam logic [7:0] SRC_LEFT_ADDR = 8'h04;
  localparam logic [7:0] SRC_RIGHT_ADDR = 8'h08;
  localparam logic [7:0] SRC_CMD_ADDR = 8'h0c;
  localparam logic [7:0] SRC_DEVRD_ADDR = 8'h10;
  localparam logic [7:0] SRC_STATUS_ADDR = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: src/audio_source_port.sv */
`timescale 1ns/1ps
// Purpose: Far end: audio source transmitter and device control writer.
// Assumes: Software drives it over AXI4-Lite on clk.
// Notes: Left and right words are sent left aligned, MSB first.
module audio_source_port (
  input wire logic clk,
  input wire logic srst,
  audio_link_if.host_end link,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  typedef struct packed {
    logic [2:0] ctrl;
    logic [31:0] left;
    logic [31:0] right;
    logic [15:0] cmd;
    logic regWr;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] clkSync;
    logic [1:0] wsSync;
    logic bclkPrev;
    logic [7:0] phaseCnt;
    logic bclkOut;
    logic wsOut;
    logic [5:0] bitIdx;
    logic wsLast;
    logic [31:0] txShift;
    logic txBit;
    logic [15:0] words;
  } src_state_t;

  src_state_t s_reg, s_next;
  logic wrTake, master, bclkNow, wsNow, fall;
  logic [31:0] newWord;
  logic [5:0] wordBits;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    master = s_reg.ctrl[audio_port_pkg::MASTER_BIT];
    wrTake = awvalid && wvalid && !s_reg.bvalid;
    s_next.regWr = 1'b0;
    if (s_reg.bvalid && bready)
      s_next.bvalid = 1'b0;
    if (wrTake)
    begin
      s_next.bvalid = 1'b1;
      s_next.bresp = audio_port_pkg::RESP_OKAY;
      case (awaddr)
        audio_port_pkg::SRC_CTRL_ADDR: s_next.ctrl = wdata[2:0];
        audio_port_pkg::SRC_LEFT_ADDR: s_next.left = wdata;
        audio_port_pkg::SRC_RIGHT_ADDR: s_next.right = wdata;
        audio_port_pkg::SRC_CMD_ADDR:
        begin
          s_next.cmd = wdata[15:0];
          s_next.regWr = wstrb[0];
        end
        audio_port_pkg::SRC_DEVRD_ADDR, audio_port_pkg::SRC_STATUS_ADDR: ;
        default: s_next.bresp = audio_port_pkg::RESP_SLVERR;
      endcase
    end
    if (s_reg.rvalid && rready)
      s_next.rvalid = 1'b0;
    if (arvalid && !s_reg.rvalid)
    begin
      s_next.rvalid = 1'b1;
      s_next.rresp = audio_port_pkg::RESP_OKAY;
      case (araddr)
        audio_port_pkg::SRC_CTRL_ADDR: s_next.rdata = {29'h0, s_reg.ctrl};
        audio_port_pkg::SRC_LEFT_ADDR: s_next.rdata = s_reg.left;
        audio_port_pkg::SRC_RIGHT_ADDR: s_next.rdata = s_reg.right;
        audio_port_pkg::SRC_CMD_ADDR: s_next.rdata = {16'h0, s_reg.cmd};
        audio_port_pkg::SRC_DEVRD_ADDR: s_next.rdata = {24'h0, link.regRdData};
        audio_port_pkg::SRC_STATUS_ADDR: s_next.rdata = {16'h0, s_reg.words};
        default:
        begin
          s_next.rdata = 32'h0;
          s_next.rresp = audio_port_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Clock generator when the source is the master (device is slave).
    wordBits = s_reg.ctrl[audio_port_pkg::WORD32_BIT] ? audio_port_pkg::LONG_BITS
      : audio_port_pkg::SHORT_BITS;
    s_next.clkSync = {s_reg.clkSync[0], link.bitClk};
    s_next.wsSync = {s_reg.wsSync[0], link.audioWordSelectPin};
    if (!master)
    begin
      s_next.phaseCnt = 8'h0;
      s_next.bclkOut = 1'b0;
      s_next.bitIdx = 6'h0;
    end
    else if (s_reg.phaseCnt >= audio_port_pkg::HALF_CYCLES - 8'h1)
    begin
      s_next.phaseCnt = 8'h0;
      s_next.bclkOut = !s_reg.bclkOut;
      if (s_reg.bclkOut)
      begin
        if (s_reg.bitIdx >= wordBits - 6'h1)
        begin
          s_next.bitIdx = 6'h0;
          s_next.wsOut = !s_reg.wsOut;
        end
        else
          s_next.bitIdx = s_reg.bitIdx + 6'h1;
      end
    end
    else
      s_next.phaseCnt = s_reg.phaseCnt + 8'h1;
    // Transmitter: data changes on each falling bit clock edge.
    bclkNow = master ? s_next.bclkOut : s_reg.clkSync[1];
    wsNow = master ? s_next.wsOut : s_reg.wsSync[1];
    fall = !bclkNow && s_reg.bclkPrev;
    s_next.bclkPrev = bclkNow;
    newWord = wsNow ? s_reg.right : s_reg.left;
    if (fall)
    begin
      s_next.wsLast = wsNow;
      if (wsNow != s_reg.wsLast && s_reg.ctrl[audio_port_pkg::LEFT_JUST_BIT])
      begin
        s_next.txBit = newWord[31];
        s_next.txShift = {newWord[30:0], 1'b0};
        s_next.words = s_reg.words + 16'h1;
      end
      else if (wsNow != s_reg.wsLast)
      begin
        s_next.txBit = s_reg.txShift[31];
        s_next.txShift = newWord;
        s_next.words = s_reg.words + 16'h1;
      end
      else
      begin
        s_next.txBit = s_reg.txShift[31];
        s_next.txShift = {s_reg.txShift[30:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign awready = wrTake;
  assign wready = wrTake;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign arready = !s_reg.rvalid;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign link.hostBitClk = s_reg.bclkOut;
  assign link.hostWordSel = s_reg.wsOut;
  assign link.hostBitClkOeN = !s_reg.ctrl[audio_port_pkg::MASTER_BIT];
  assign link.hostWordSelOeN = !s_reg.ctrl[audio_port_pkg::MASTER_BIT];
  assign link.audioSerialDataPin = s_reg.txBit;
  assign link.regAddr = s_reg.cmd[15:8];
  assign link.regWrData = s_reg.cmd[7:0];
  assign link.regWrite = s_reg.regWr;
endmodule

/* File: test/audio_link_checker_sva.sv */
// Purpose: Assertions on the audio link and on the device control port.
// Assumes: Shadows the setup and interface bytes from the control writes.
// Notes: Clock and word counts are judged only after two clean edges.
`timescale 1ns/1ps
module audio_link_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic devBitClkOeN,
  input wire logic devWordSelOeN,
  input wire logic bitClk,
  input wire logic audioWordSelectPin,
  input wire logic audioSerialDataPin,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic [7:0] regRdData
);
  logic bcPrev, wsPrev;
  logic [7:0] runCnt, setupReg, ifReg;
  logic [5:0] riseCnt;
  logic [1:0] edgeSeen, wsSeen;
  wire logic master = !devBitClkOeN;
  wire logic bitEdge = bitClk != bcPrev;
  wire logic wsEdge = audioWordSelectPin != wsPrev;
  wire logic usb = setupReg[1:0] == 2'h0;
  wire logic mapped = regAddr >= 8'h0e && regAddr <= 8'h15;
  wire logic cfgWr = regWrite && (regAddr == 8'h0e || regAddr == 8'h0f);
  wire logic [5:0] expBits = usb ? 6'h19 : (ifReg[1] ? 6'h20 : 6'h10);
  wire logic [7:0] expHigh = usb ? 8'h24 : 8'h2d;
  wire logic [7:0] expLow = usb ? 8'h36 : 8'h2d;
  // ---------------------------------------------------------------
  // Edge and count tracking.
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    bcPrev <= bitClk;
    wsPrev <= audioWordSelectPin;
    if (srst)
    begin
      setupReg <= 8'h00;
      ifReg <= 8'h00;
    end
    else if (regWrite && regAddr == 8'h0e)
      setupReg <= regWrData;
    else if (regWrite && regAddr == 8'h0f)
      ifReg <= regWrData;
    if (srst || !master || cfgWr)
    begin
      runCnt <= 8'h00;
      riseCnt <= 6'h00;
      edgeSeen <= 2'h0;
      wsSeen <= 2'h0;
    end
    else
    begin
      runCnt <= bitEdge ? 8'h01 : runCnt + 8'h01;
      if (bitEdge && edgeSeen != 2'h2)
        edgeSeen <= edgeSeen + 2'h1;
      if (wsEdge)
        riseCnt <= 6'h00;
      else if (bitEdge && bitClk)
        riseCnt <= riseCnt + 6'h01;
      if (wsEdge && wsSeen != 2'h2)
        wsSeen <= wsSeen + 2'h1;
    end
  end
  // ---------------------------------------------------------------
  // Properties.
  // ---------------------------------------------------------------
  default clocking dc @(posedge clk); endclocking
  default disable iff (srst);
  chk_oe_pair: assert property (devWordSelOeN == devBitClkOeN)
    else $error("Clock and word select enables differ.");
  chk_master_follow: assert property (
    regWrite && regAddr == 8'h0f |-> ##2 devBitClkOeN == !$past(regWrData[0], 2))
    else $error("Clock role does not follow the master bit.");
  chk_word_bits: assert property (
    wsEdge && master && wsSeen == 2'h2 |-> riseCnt == expBits)
    else $error("Wrong bit clock count per word.");
  chk_high_time: assert property (
    bitEdge && master && bcPrev && edgeSeen == 2'h2 |-> runCnt == expHigh)
    else $error("Wrong bit clock high time.");
  chk_low_time: assert property (
    bitEdge && master && !bcPrev && edgeSeen == 2'h2 |-> runCnt == expLow)
    else $error("Wrong bit clock low time.");
  chk_ws_on_low: assert property (
    wsEdge && master && $past(master) |-> !bitClk)
    else $error("Word select moved while bit clock high.");
  chk_data_on_low: assert property ($changed(audioSerialDataPin) |-> !bitClk)
    else $error("Serial data moved while bit clock high.");
  chk_reg_readback: assert property (
    regWrite && mapped ##1 !regWrite |=> regRdData == $past(regWrData, 2))
    else $error("Control register read back differs.");
  chk_unmapped_zero: assert property (
    regWrite && !mapped ##1 !regWrite |=> regRdData == 8'h00)
    else $error("Unmapped control address reads non-zero.");
endmodule

/* File: test/i2s_port_and_dac_fir_coeffs_test.sv */
// Purpose: Self-checking bench joining the audio source and the device end.
// Assumes: Software reaches the source over AXI4-Lite.
// Notes: Five framing rows cover both roles, word lengths and timings.
`timescale 1ns/1ps
`define CHECK_EQ(what, exp, got) \
  begin \
    nTests++; \
    if ((got) !== (exp)) \
    begin \
      errorCnt++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end
module i2s_port_and_dac_fir_coeffs_test;
  logic clk = 1'b0;
  logic srst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, sampleValid, fastControlMode;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, leftSample, rightSample, mask, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] tapZeroCoef, tapOneCoef, tapCentreCoef, tapThreeCoef, tapFourCoef;
  int errorCnt = 0;
  int nTests = 0;
  logic [7:0] srcTab [5] = '{8'h01, 8'h07, 8'h02, 8'h04, 8'h02};
  logic [7:0] ifTab [5] = '{8'h00, 8'h04, 8'h01, 8'h05, 8'h03};
  logic [7:0] setTab [5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01};
  int bitTab [5] = '{16, 32, 25, 16, 32};
  audio_link_if audio_link_if_i ();
  audio_dac_port audio_dac_port_i (.clk(clk), .srst(srst), .link(audio_link_if_i),
    .leftSample(leftSample), .rightSample(rightSample), .sampleValid(sampleValid),
    .tapZeroCoef(tapZeroCoef), .tapOneCoef(tapOneCoef), .tapCentreCoef(tapCentreCoef),
    .tapThreeCoef(tapThreeCoef), .tapFourCoef(tapFourCoef),
    .fastControlMode(fastControlMode));
  audio_source_port audio_source_port_i (.clk(clk), .srst(srst), .link(audio_link_if_i),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  audio_link_checker audio_link_checker_i (.clk(clk), .srst(srst),
    .devBitClkOeN(audio_link_if_i.devBitClkOeN),
    .devWordSelOeN(audio_link_if_i.devWordSelOeN), .bitClk(audio_link_if_i.bitClk),
    .audioWordSelectPin(audio_link_if_i.audioWordSelectPin),
    .audioSerialDataPin(audio_link_if_i.audioSerialDataPin),
    .regAddr(audio_link_if_i.regAddr), .regWrData(audio_link_if_i.regWrData),
    .regWrite(audio_link_if_i.regWrite), .regRdData(audio_link_if_i.regRdData));
  always #2 clk = ~clk;
  // ---------------------------------------------------------------
  // Bus and check tasks.
  // ---------------------------------------------------------------
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic devWrite(input logic [7:0] a, input logic [7:0] d);
    axiWrite(8'h0c, {16'h0000, a, d});
  endtask
  task automatic devCheck(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    devWrite(a, d);
    repeat (3) @(posedge clk);
    axiRead(8'h10, rd, r);
    `CHECK_EQ("readBack", a >= 8'h0e && a <= 8'h15 ? d : 8'h00, rd[7:0])
  endtask
  task automatic checkTaps(input logic [15:0] o, input logic [15:0] i, input logic [15:0] c);
    @(posedge clk);
    `CHECK_EQ("tapZero", o, tapZeroCoef)
    `CHECK_EQ("tapOne", i, tapOneCoef)
    `CHECK_EQ("tapCentre", c, tapCentreCoef)
    `CHECK_EQ("tapThree", i, tapThreeCoef)
    `CHECK_EQ("tapFour", o, tapFourCoef)
  endtask
  task automatic wireMsb(input logic lj);
    logic b1, b2;
    repeat (2) @(negedge audio_link_if_i.audioWordSelectPin);
    @(posedge audio_link_if_i.bitClk);
    b1 = audio_link_if_i.audioSerialDataPin;
    @(posedge audio_link_if_i.bitClk);
    b2 = audio_link_if_i.audioSerialDataPin;
    `CHECK_EQ("msbPlace", lj ? 2'h2 : 2'h1, {b1, b2})
    @(posedge clk);
  endtask
  task automatic tallyAndFinish();
    $display("Checks %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Test sequence.
  // ---------------------------------------------------------------
  initial
  begin
    logic [1:0] resp;
    srst <= 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
    {awaddr, araddr, wdata} <= 48'h0;
    wstrb <= 4'hf;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    checkTaps(16'h01b2, 16'hf70d, 16'h6968);
    for (int k = 1; k < 4; k++)
    begin
      devWrite(8'h0e, 8'(k));
      checkTaps(16'h003d, 16'hfe8d, 16'h6463);
    end
    devCheck(8'h0f, 8'h08);
    `CHECK_EQ("fastMode", 1'b1, fastControlMode)
    devCheck(8'h0f, 8'h00);
    `CHECK_EQ("fastMode", 1'b0, fastControlMode)
    for (int k = 0; k < 6; k++)
      devCheck(8'h10 + 8'(k), 8'hf0 + 8'(k));
    devWrite(8'h0e, 8'h40);
    checkTaps(16'hf1f0, 16'hf3f2, 16'hf5f4);
    devWrite(8'h0e, 8'h00);
    checkTaps(16'h01b2, 16'hf70d, 16'h6968);
    devCheck(8'h20, 8'h55);
    axiRead(8'h40, rd, resp);
    `CHECK_EQ("unmappedResp", 2'h2, resp)
    axiWrite(8'h04, 32'h8123_4567);
    axiWrite(8'h08, 32'h5a5a_c342);
    for (int r = 0; r < 5; r++)
    begin
      devWrite(8'h0f, 8'h00);
      axiWrite(8'h00, 32'h0);
      devWrite(8'h0e, setTab[r]);
      devWrite(8'h0f, ifTab[r]);
      axiWrite(8'h00, {24'h0, srcTab[r]});
      wireMsb(ifTab[r][2]);
      do @(posedge clk); while (sampleValid !== 1'b1);
      mask = ~(32'hffff_ffff >> bitTab[r]);
      `CHECK_EQ("leftWord", 32'h8123_4567 & mask, leftSample)
      `CHECK_EQ("rightWord", 32'h5a5a_c342 & mask, rightSample)
    end
    tallyAndFinish();
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    errorCnt++;
    tallyAndFinish();
  end
endmodule
